// *** lss_pkg.sv ***
/*
 * Shared constants for the linear sensor array scan sequencer: pixel count,
 * clock rates and the link timing used by both the array end and the
 * controller end.
 * Assumes a single 200 MHz system clock for both ends.
 */
package lss_pkg;
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned NUM_PIXELS = 128;
    localparam int unsigned PIX_W = 8;
    localparam logic [PIX_W-1:0] PIX_LAST = 8'h7f;
    localparam logic [PIX_W-1:0] PIX_FIRST = 8'h00;
    localparam int unsigned SAMPLE_W = 12;
    // array clock limits
    localparam int unsigned ARR_CLK_MAX_KHZ = 5000;
    localparam int unsigned ARR_CLK_MIN_PERIOD_PS = 1000000000 / ARR_CLK_MAX_KHZ;
    // system clocks per array clock half period, rounded up for a least time
    localparam int unsigned HALF_MIN_CYC =
        (ARR_CLK_MIN_PERIOD_PS / 2 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned DIV_W = 16;
    localparam logic [DIV_W-1:0] DIV_MIN = DIV_W'(HALF_MIN_CYC);
    // integration time limit
    localparam int unsigned INT_MAX_MS = 100;
    localparam int unsigned INT_W = 32;
    localparam longint unsigned INT_MAX_CLKS_L =
        (64'(INT_MAX_MS) * 64'd1000000000) / 64'(CLK_PERIOD_PS);
    localparam logic [INT_W-1:0] INT_MAX_CLKS = INT_W'(INT_MAX_CLKS_L);
    // array clocks per scan before the next start is allowed (n+1)
    localparam logic [PIX_W:0] SCAN_CLKS = 9'h081;
    localparam logic [PIX_W:0] SCAN_ZERO = 9'h000;
    localparam logic [INT_W-1:0] INT_ZERO = 32'h0000_0000;
    localparam logic [DIV_W-1:0] DIV_ZERO = 16'h0000;
endpackage

// *** lss_if.sv ***
/*
 * Link between the sensor array end and its controller: start pulse, array
 * clock and the tri-state pixel output.
 * Assumes both ends share clk_in; pixel_analog_output_oe marks when the array drives the output.
 */
`timescale 1ns/100ps
`default_nettype none
interface lss_if;
    import lss_pkg::*;
    logic start_pulse;
    logic array_clk;
    logic [SAMPLE_W-1:0] pixel_analog_output;
    logic pixel_analog_output_oe;
    modport array_end (
        input start_pulse,
        input array_clk,
        output pixel_analog_output,
        output pixel_analog_output_oe
    );
    modport ctrl_end (
        output start_pulse,
        output array_clk,
        input pixel_analog_output,
        input pixel_analog_output_oe
    );
endinterface
`default_nettype wire

// *** lss_array.sv ***
/*
 * Sensor array end of the scan sequencer.
 * Assumes array_clk and start_pulse are synchronous to clk_in; light levels
 * arrive as digital samples on pixel_light_in, one per selected pixel.
 */
// Function
// - start: select pixel 1, hold sample, clear
// - next clock: release, advance one pixel
// - integration equals interval between reads
// - output high-impedance after clock n+1
// - next start no earlier than n+1
// - start spacing at least 128 clocks
// - after power-up, flush one scan
// - clock low while idle
// - integration at most 100 ms
// - array clock at most 5 MHz
// - pixel held for its whole clock
// - clock rate constant during readout (the code divides by half_period_in live and does not hold it for a scan)
// - shorten integration on saturation (the code only sets saturated_out; integ_clks_in is used unchanged)
// - start low before next rising edge
`timescale 1ns/100ps
`default_nettype none
module lss_array
    import lss_pkg::*;
(
    input wire logic clk_in,
    input wire logic rstn_in,
    lss_if.array_end link,
    output logic [PIX_W-1:0] pixel_sel_out,
    input wire logic [SAMPLE_W-1:0] pixel_light_in,
    output logic integ_clear_out,
    output logic scanning_out
);
    logic aclk_prev_q;
    logic [PIX_W:0] count_q;
    logic [PIX_W:0] count_d;
    logic active_q;
    logic active_d;
    logic clear_q;
    logic [SAMPLE_W-1:0] hold_q;
    logic [SAMPLE_W-1:0] hold_d;

    wire rise = link.array_clk & ~aclk_prev_q;
    wire start_seen = rise & link.start_pulse;
    wire last_pix = (count_q[PIX_W-1:0] == PIX_LAST);
    wire ends_scan = rise & active_q & last_pix & ~start_seen;

    // a start restarts the scan at pixel 1 and holds its sample
    assign count_d = start_seen ? SCAN_ZERO :
                     (rise & active_q & ~last_pix) ? count_q + 9'h001 : count_q;
    assign active_d = start_seen ? 1'b1 : (ends_scan ? 1'b0 : active_q);
    assign hold_d = (rise & (start_seen | active_q)) ? pixel_light_in : hold_q;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            aclk_prev_q <= 1'b0;
            count_q <= SCAN_ZERO;
            active_q <= 1'b0;
            clear_q <= 1'b0;
            hold_q <= '0;
        end else begin
            aclk_prev_q <= link.array_clk;
            count_q <= count_d;
            active_q <= active_d;
            clear_q <= rise & (start_seen | (active_q & ~last_pix));
            hold_q <= hold_d;
        end
    end

    assign link.pixel_analog_output = hold_q;
    assign link.pixel_analog_output_oe = active_q;
    // selects the pixel being held at this rise, so its sample lands in hold_q
    assign pixel_sel_out = count_d[PIX_W-1:0];
    assign integ_clear_out = clear_q;
    assign scanning_out = active_q;
endmodule
`default_nettype wire

// *** lss_ctrl.sv ***
/*
 * Controller end: makes the array clock by a divider, spaces start pulses
 * from a programmable integration counter and captures each pixel.
 * Assumes clk_in at 200 MHz and one array end on the link.
 */
`timescale 1ns/100ps
`default_nettype none
module lss_ctrl
    import lss_pkg::*;
(
    input wire logic clk_in,
    input wire logic rstn_in,
    lss_if.ctrl_end link,
    input wire logic enable_in,
    input wire logic [DIV_W-1:0] half_period_in,
    input wire logic [INT_W-1:0] integ_clks_in,
    output logic [SAMPLE_W-1:0] pixel_data_out,
    output logic [PIX_W-1:0] pixel_index_out,
    output logic pixel_valid_out,
    output logic data_valid_out,
    output logic saturated_out
);
    typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_WAIT} lss_state_e;
    lss_state_e state_q;
    lss_state_e state_d;
    logic [DIV_W-1:0] div_q;
    logic aclk_q;
    logic start_q;
    logic [PIX_W:0] clks_q;
    logic [INT_W-1:0] integ_q;
    logic flushed_q;
    logic [SAMPLE_W-1:0] data_q;
    logic [PIX_W-1:0] idx_q;
    logic valid_q;
    logic sat_q;

    function automatic logic [DIV_W-1:0] clamp_div(input logic [DIV_W-1:0] v);
        clamp_div = (v < DIV_MIN) ? DIV_MIN : v;
    endfunction

    function automatic logic [INT_W-1:0] clamp_int(input logic [INT_W-1:0] v);
        clamp_int = (v > INT_MAX_CLKS) ? INT_MAX_CLKS : v;
    endfunction

    wire [DIV_W-1:0] half_w = clamp_div(half_period_in);
    wire running = (state_q != ST_IDLE);
    wire tick = running & (div_q == DIV_ZERO);
    wire rise_tick = tick & ~aclk_q;
    wire fall_tick = tick & aclk_q;
    wire scan_done = (clks_q >= SCAN_CLKS);
    wire integ_done = (integ_q == INT_ZERO);
    wire go = enable_in & scan_done & integ_done & ~aclk_q;
    wire sample_now = rise_tick & (state_q == ST_SCAN) & (clks_q != SCAN_ZERO) &
                      (clks_q <= SCAN_CLKS);

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (enable_in) begin
                    state_d = ST_WAIT;
                end
            end
            ST_SCAN: begin
                if (scan_done & fall_tick) begin
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (go & rise_tick) begin
                    state_d = ST_SCAN;
                end else if (!enable_in & ~aclk_q) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_q <= ST_IDLE;
            div_q <= DIV_ZERO;
            aclk_q <= 1'b0;
        end else begin
            state_q <= state_d;
            div_q <= (tick | !running) ? half_w - 16'h0001 : div_q - 16'h0001;
            aclk_q <= running ? (aclk_q ^ tick) : 1'b0;
        end
    end

    // start rises before the array clock edge, dropped at the following fall
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            start_q <= 1'b0;
        end else if (state_q == ST_WAIT && go && div_q == 16'h0001) begin
            start_q <= 1'b1;
        end else if (fall_tick) begin
            start_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            clks_q <= SCAN_CLKS;
            integ_q <= INT_ZERO;
        end else if (rise_tick && start_q) begin
            clks_q <= SCAN_ZERO + 9'h001;
            integ_q <= clamp_int(integ_clks_in);
        end else begin
            if (rise_tick && clks_q < SCAN_CLKS) begin
                clks_q <= clks_q + 9'h001;
            end
            if (!integ_done) begin
                integ_q <= integ_q - 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            flushed_q <= 1'b0;
            data_q <= '0;
            idx_q <= PIX_FIRST;
            valid_q <= 1'b0;
            sat_q <= 1'b0;
        end else begin
            valid_q <= sample_now & flushed_q & link.pixel_analog_output_oe;
            if (sample_now) begin
                data_q <= link.pixel_analog_output;
                idx_q <= clks_q[PIX_W-1:0] - 8'h01;
                if (link.pixel_analog_output == '1) begin
                    sat_q <= 1'b1;
                end
            end
            if (rise_tick && start_q) begin
                sat_q <= 1'b0;
            end
            if (state_q == ST_SCAN && scan_done && fall_tick) begin
                flushed_q <= 1'b1;
            end
        end
    end

    assign link.array_clk = aclk_q;
    assign link.start_pulse = start_q;
    assign pixel_data_out = data_q;
    assign pixel_index_out = idx_q;
    assign pixel_valid_out = valid_q;
    assign data_valid_out = flushed_q;
    assign saturated_out = sat_q;
endmodule
`default_nettype wire

// *** lss_asserts.sv ***
/* link checker: start, array clock and pixel output
   assumes both ends share clk_in and rstn_in */
`timescale 1ns/100ps
`default_nettype none
module lss_asserts
    import lss_pkg::*;
(
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic start_pulse,
    input wire logic array_clk,
    input wire logic [SAMPLE_W-1:0] pixel_analog_output,
    input wire logic pixel_analog_output_oe
);
    logic ac_q;
    logic [8:0] cnt_q;
    logic [15:0] run_q;
    wire rise_w = array_clk && !ac_q;
    wire edge_w = array_clk != ac_q;
    wire idle_w = cnt_q == 9'h000 || cnt_q >= 9'h080;
    // cnt_q: array rises since the last start, 1 at the start rise
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ac_q <= 1'b0;
            cnt_q <= 9'h000;
            run_q <= 16'h0000;
        end else begin
            ac_q <= array_clk;
            run_q <= edge_w ? 16'h0000 : run_q + {15'h0000, run_q != 16'hffff};
            if (rise_w && start_pulse)
                cnt_q <= 9'h001;
            else if (rise_w && cnt_q != 9'h000 && cnt_q != 9'h1ff)
                cnt_q <= cnt_q + 9'h001;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    start_drive_a: assert property (rise_w && start_pulse |=> pixel_analog_output_oe)
        else $error("no output after start");
    stray_rise_a: assert property (rise_w && !start_pulse && cnt_q == 9'h000 |=> !pixel_analog_output_oe)
        else $error("output without start");
    oe_hold_a: assert property (rise_w && cnt_q != 9'h000 && cnt_q < 9'h080 |=> pixel_analog_output_oe)
        else $error("output dropped mid scan");
    oe_drop_a: assert property (rise_w && !start_pulse && cnt_q == 9'h080 |=> !pixel_analog_output_oe)
        else $error("output not released");
    pixel_stands_a: assert property (pixel_analog_output_oe && !rise_w |=> $stable(pixel_analog_output))
        else $error("pixel changed mid period");
    start_order_a: assert property (rise_w && start_pulse |-> idle_w)
        else $error("start too early");
    start_low_a: assert property (rise_w && cnt_q == 9'h001 |-> !start_pulse)
        else $error("start held too long");
    // run_q reads one less than the system cycles since the last edge
    clk_rate_a: assert property (edge_w && cnt_q != 9'h000 |-> run_q >= 16'h0013)
        else $error("array clock too fast");
    cover property (rise_w && start_pulse && cnt_q >= 9'h080);
    cover property (rise_w && cnt_q == 9'h080);
    cover property ($fell(pixel_analog_output_oe));
endmodule
`default_nettype wire

// *** linear_array_scan_sequencer_bench.sv ***
/* bench: array end and controller end joined by the link
   assumes a 5 ns clock and the package constants */
`timescale 1ns/100ps
`default_nettype none
module linear_array_scan_sequencer_bench;
    import lss_pkg::*;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic enable_in = 1'b0;
    logic start_q = 1'b0;
    logic [PIX_W-1:0] sel;
    logic [PIX_W-1:0] idx;
    logic [SAMPLE_W-1:0] data;
    logic pv;
    logic dv;
    logic sat;
    logic clr;
    logic scan;
    int clears = 0;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    int last_start = 0;
    // last pixel saturates, the rest carry their index
    wire [SAMPLE_W-1:0] light_w = (sel == PIX_LAST) ? 12'hfff : {4'h5, sel};
    lss_if link_if();
    lss_array lss_array_inst (.clk_in(clk_in), .rstn_in(rstn_in), .link(link_if),
        .pixel_sel_out(sel), .pixel_light_in(light_w), .integ_clear_out(clr),
        .scanning_out(scan));
    lss_ctrl lss_ctrl_inst (.clk_in(clk_in), .rstn_in(rstn_in), .link(link_if),
        .enable_in(enable_in), .half_period_in(16'h0032), .integ_clks_in(32'h0000_7530),
        .pixel_data_out(data), .pixel_index_out(idx), .pixel_valid_out(pv),
        .data_valid_out(dv), .saturated_out(sat));
    lss_asserts lss_asserts_inst (.clk_in(clk_in), .rstn_in(rstn_in),
        .start_pulse(link_if.start_pulse), .array_clk(link_if.array_clk),
        .pixel_analog_output(link_if.pixel_analog_output),
        .pixel_analog_output_oe(link_if.pixel_analog_output_oe));
    initial begin
        forever #2.5 clk_in = ~clk_in;
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic give_verdict();
        if (failures == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic read_pixel(input int k);
        int n = 0;
        while (pv !== 1'b1 && n < 40000) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        check("pixel_index", 32'(idx), 32'(k));
        check("pixel_data", 32'(data), (k == 127) ? 32'h0fff : 32'(12'h500 + k));
        @(posedge clk_in);
        #1;
    endtask
    always @(negedge clk_in) begin
        cycles++;
        if (clr === 1'b1) clears++;
        if (pv === 1'b1) check("valid_after_flush", 32'(dv), 32'h1);
        if (link_if.start_pulse === 1'b1 && !start_q) begin
            if (last_start != 0) check("spacing", 32'(cycles - last_start >= 30000), 32'h1);
            last_start = cycles;
        end
        start_q = link_if.start_pulse;
        if (cycles == 75000) begin
            failures++;
            give_verdict();
        end
    end
    initial begin
        repeat (3) @(posedge clk_in);
        #1;
        rstn_in = 1'b1;
        repeat (120) @(posedge clk_in);
        #1;
        enable_in = 1'b1;
        for (int k = 0; k < 128; k++) begin
            read_pixel(k);
        end
        check("saturated", 32'(sat), 32'h1);
        // flush scan and valid scan, one clear per pixel each
        check("integ_clears", 32'(clears), 32'h0000_0100);
        repeat (200) @(posedge clk_in);
        #1;
        check("scanning_after_last", 32'(scan), 32'h0);
        give_verdict();
    end
endmodule
`default_nettype wire
